/* verilog/lcdp_pkg.sv */
// Constants for the character display host bus port: register map,
// field positions and reset values.
// Assumes a single 100 MHz system clock and an AXI4-Lite master.
// Operation
// - Select high routes reads, writes to data
// - Select low: instruction write, status read
// - Read/write high: device drives data lines
// - Read/write low: device captures host data
// - Every transfer framed by host strobe pulse
// - Eight-line bidirectional bus, driven per direction
// - Four-line width uses only upper lines
// - Four-line width: high nibble, then low
// - Eight-line width: one strobe per byte
// - Width bit in configuration instruction selects width
// - Status read returns busy and address counter
package lcdp_pkg;
  // Register byte offsets
  localparam logic [7:0] LCDP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] LCDP_STAT_OFS   = 8'h04;
  localparam logic [7:0] LCDP_RXDATA_OFS = 8'h08;
  localparam logic [7:0] LCDP_RDBYTE_OFS = 8'h0c;
  localparam logic [7:0] LCDP_ADDR_OFS   = 8'h10;
  // Control fields
  localparam int CTRL_WIDTH8_BIT    = 0;
  localparam int CTRL_BUSYCLR_BIT   = 1;
  // Status fields
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_EMPTY_BIT     = 1;
  localparam int STAT_OVERFLOW_BIT  = 2;
  localparam int STAT_WIDTH8_BIT    = 3;
  // Received word fields
  localparam int RX_VALID_BIT       = 31;
  localparam int RX_SELECT_BIT      = 8;
  // Configuration instruction: top three bits 001, width bit 4
  localparam logic [2:0] FUNC_SET_CODE  = 3'h1;
  localparam int         FUNC_WIDTH_BIT = 4;
  // Reset values
  localparam logic       WIDTH8_RST  = 1'h1;
  localparam logic [6:0] ADDR_RST    = 7'h00;
  localparam logic [7:0] RDBYTE_RST  = 8'h00;
  // Buffer shape
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Nibble phase of a four-line transfer
  typedef enum logic [1:0] {
    PH_HIGH = 2'b01,
    PH_LOW  = 2'b10
  } lcdp_phase_t;
endpackage

/* verilog/lcdp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty come from an occupancy count.
`timescale 1ns/10ps
module lcdp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Honest flags straight from the count
  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem[rdPtr_r];

  // Storage has no reset; only pointers and count need a defined value
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= push ? wrPtr_r + AW'(1) : wrPtr_r;
      rdPtr_r <= pop ? rdPtr_r + AW'(1) : rdPtr_r;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* verilog/lcdp_host_port.sv */
// Host parallel bus port of a character display controller, with an
// AXI4-Lite register slave on the inside and a FIFO of received words.
// Assumes pin inputs already synchronous to clk_sys; the bench resolves
// the shared data wire from dataLinesOe.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module lcdp_host_port (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Host bus pins
  input  wire logic                    registerSelect,
  input  wire logic                    readWriteSelect,
  input  wire logic                    busStrobe,
  input  wire logic [7:0]              dataLinesIn,
  output logic [7:0]                   dataLinesOut,
  output logic                         dataLinesOe
);
  import lcdp_pkg::*;

  logic                  strobePrev_r;
  lcdp_phase_t           phase_r, phase_nxt;
  logic [3:0]            hiNib_r;
  logic                  width8_r, width8_nxt;
  logic                  busy_r, busy_nxt;
  logic                  overflow_r, overflow_nxt;
  logic [6:0]            addrCnt_r, addrCnt_nxt;
  logic [7:0]            rdByte_r, rdByte_nxt;
  logic [7:0]            dataOut_r;
  logic                  dataOe_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  rvalid_r;
  logic [1:0]            rresp_r;
  logic [31:0]           rdata_r, rdata_nxt;

  // Strobe edges; pins count as synchronous so one stage suffices
  wire strobeRise = busStrobe & ~strobePrev_r;
  wire strobeFall = ~busStrobe & strobePrev_r;
  wire lastNibble = width8_r | (phase_r == PH_LOW);
  wire byteDone   = strobeFall & lastNibble;
  wire byteWrite  = byteDone & ~readWriteSelect;
  wire byteRead   = byteDone & readWriteSelect;

  // Assemble the written byte: full bus, or held high nibble plus upper lines
  wire [7:0] wrByte = width8_r ? dataLinesIn
                               : {hiNib_r, dataLinesIn[7:4]};

  // Instruction decode of a completed write with select low
  wire instrWrite = byteWrite & ~registerSelect;
  wire dataWrite  = byteWrite & registerSelect;
  wire dataRead   = byteRead & registerSelect;
  wire funcSet    = instrWrite & (wrByte[7:5] == FUNC_SET_CODE);
  wire setDdAddr  = instrWrite & wrByte[7];
  wire setCgAddr  = instrWrite & (wrByte[7:6] == 2'h1);

  // FIFO keeps both data and instructions, tagged by the select level
  logic       fifoInReady;
  logic       fifoOutValid;
  logic [8:0] fifoOutData;
  wire        fifoPop;

  // A full FIFO shows as busy, so a polling host stalls rather than overflows
  wire busyOut = busy_r | ~fifoInReady;

  // Byte offered on a read: data register or busy/address word
  wire [7:0] readByte = registerSelect ? rdByte_r
                                       : {busyOut, addrCnt_r};
  wire [7:0] driveVal = width8_r ? readByte
                      : (phase_r == PH_HIGH) ? {readByte[7:4], 4'h0}
                                             : {readByte[3:0], 4'h0};

  lcdp_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (byteWrite),
    .inReady  (fifoInReady),
    .inData   ({registerSelect, wrByte}),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  // AXI handshakes: write takes address and data together, one in flight
  wire wrTake  = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  wire rdTake  = s_axi_arvalid & ~rvalid_r;
  // Every writable field lives in byte 0, so lane 0 alone gates a register write
  wire wrLane0 = wrTake & s_axi_wstrb[0];
  wire wrCtrl  = wrLane0 & (s_axi_awaddr == LCDP_CTRL_OFS);
  wire wrStat  = wrLane0 & (s_axi_awaddr == LCDP_STAT_OFS);
  wire wrRdB   = wrLane0 & (s_axi_awaddr == LCDP_RDBYTE_OFS);
  wire wrAddr  = wrLane0 & (s_axi_awaddr == LCDP_ADDR_OFS);
  // Offsets that take a write; reads also accept the buffer head
  function automatic logic isRegOfs(input logic [7:0] a);
    isRegOfs = (a == LCDP_CTRL_OFS) | (a == LCDP_STAT_OFS)
             | (a == LCDP_RDBYTE_OFS) | (a == LCDP_ADDR_OFS);
  endfunction

  wire wrOk    = isRegOfs(s_axi_awaddr);
  wire rdOk    = isRegOfs(s_axi_araddr) | (s_axi_araddr == LCDP_RXDATA_OFS);
  assign fifoPop = rdTake & (s_axi_araddr == LCDP_RXDATA_OFS);

  // Readies are combinational so a take costs no extra cycle
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = rdTake;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // Read data mux; a pop samples the FIFO head in the same cycle
  always_comb begin
    rdata_nxt = 32'h0;
    unique case (s_axi_araddr)
      LCDP_CTRL_OFS:   rdata_nxt[CTRL_WIDTH8_BIT] = width8_r;
      LCDP_STAT_OFS: begin
        rdata_nxt[STAT_BUSY_BIT]     = busyOut;
        rdata_nxt[STAT_EMPTY_BIT]    = ~fifoOutValid;
        rdata_nxt[STAT_OVERFLOW_BIT] = overflow_r;
        rdata_nxt[STAT_WIDTH8_BIT]   = width8_r;
      end
      LCDP_RXDATA_OFS: begin
        rdata_nxt[RX_VALID_BIT]  = fifoOutValid;
        rdata_nxt[RX_SELECT_BIT:0] = fifoOutValid ? fifoOutData : 9'h0;
      end
      LCDP_RDBYTE_OFS: rdata_nxt[7:0] = rdByte_r;
      LCDP_ADDR_OFS:   rdata_nxt[6:0] = addrCnt_r;
      default:         rdata_nxt = 32'h0;
    endcase
  end

  // Nibble phase; a width change restarts at the high nibble
  always_comb begin
    phase_nxt = phase_r;
    if (funcSet || wrCtrl) begin
      phase_nxt = PH_HIGH;
    end else if (strobeFall && !width8_r) begin
      phase_nxt = (phase_r == PH_HIGH) ? PH_LOW : PH_HIGH;
    end
  end

  // Width: configuration instruction wins over a software write
  assign width8_nxt = funcSet ? wrByte[FUNC_WIDTH_BIT]
                    : wrCtrl  ? s_axi_wdata[CTRL_WIDTH8_BIT] : width8_r;

  // Busy set by each instruction; the set wins over a software clear
  assign busy_nxt = instrWrite ? 1'b1
                  : (wrCtrl & s_axi_wdata[CTRL_BUSYCLR_BIT]) ? 1'b0 : busy_r;

  // Overflow is sticky, write-one-to-clear, with set winning
  assign overflow_nxt = (byteWrite & ~fifoInReady) ? 1'b1
                      : (wrStat & s_axi_wdata[STAT_OVERFLOW_BIT]) ? 1'b0 : overflow_r;

  // Address counter: address instructions, software load, data access step
  assign addrCnt_nxt = setDdAddr ? wrByte[6:0]
                     : setCgAddr ? {1'b0, wrByte[5:0]}
                     : wrAddr    ? s_axi_wdata[6:0]
                     : (dataWrite | dataRead) ? addrCnt_r + 7'h1 : addrCnt_r;

  assign rdByte_nxt = wrRdB ? s_axi_wdata[7:0] : rdByte_r;

  // Drive the lines from just after a read strobe rises until one cycle after it falls, from a flop
  assign dataLinesOut = dataOut_r;
  assign dataLinesOe  = dataOe_r;

  // Byte latched at the rise, so it cannot change while the host samples it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dataOe_r  <= 1'b0;
      dataOut_r <= 8'h00;
    end else if (strobeRise && readWriteSelect) begin
      dataOe_r  <= 1'b1;
      dataOut_r <= driveVal;
    end else if (strobeFall) begin
      dataOe_r  <= 1'b0;
    end
  end

  // Upper nibble of a four-line write held for the second strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hiNib_r <= 4'h0;
    end else if (strobeFall && !width8_r && phase_r == PH_HIGH) begin
      hiNib_r <= dataLinesIn[7:4];
    end
  end

  // Strobe history; resets to the idle level so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strobePrev_r <= 1'b0;
    end else begin
      strobePrev_r <= busStrobe;
    end
  end

  // Nibble phase; a host starts at the high nibble after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_r <= PH_HIGH;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Bus width; eight lines after reset so any host can reconfigure it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      width8_r <= WIDTH8_RST;
    end else begin
      width8_r <= width8_nxt;
    end
  end

  // Busy flag; no internal timer, so only software ends an instruction
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // Sticky buffer overflow
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overflow_r <= 1'b0;
    end else begin
      overflow_r <= overflow_nxt;
    end
  end

  // Address counter, seven bits as it appears in the status word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addrCnt_r <= ADDR_RST;
    end else begin
      addrCnt_r <= addrCnt_nxt;
    end
  end

  // Byte offered to host data reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdByte_r <= RDBYTE_RST;
    end else begin
      rdByte_r <= rdByte_nxt;
    end
  end

  // Write response one cycle after the take, held until accepted
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wrTake) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read answer one cycle after the take, held until accepted
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (rdTake) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rdOk ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= rdata_nxt;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule

/* testbench/lcdp_host_port_chk.sv */
// Checker for the display port: host pin timing and register bus answers.
// Assumes a bind to lcdp_host_port; sees only its ports.
`timescale 1ns/10ps
module lcdp_host_port_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Host pins
  input wire logic        readWriteSelect,
  input wire logic        busStrobe,
  input wire logic [7:0]  dataLinesOut,
  input wire logic        dataLinesOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Pin drive must follow strobe and direction, else the wire fights
  rd_drive_a: assert property (busStrobe && readWriteSelect |=> dataLinesOe)
    else $error("lines not driven in read");
  wr_quiet_a: assert property (busStrobe && !readWriteSelect |=> !dataLinesOe)
    else $error("lines driven in write");
  read_release_a: assert property ($fell(busStrobe) |-> ##1 !dataLinesOe)
    else $error("lines held after strobe");
  drive_cause_a: assert property (dataLinesOe |-> $past(busStrobe) && $past(readWriteSelect))
    else $error("drive without read strobe");
  drive_hold_a: assert property (dataLinesOe && $past(dataLinesOe) |-> $stable(dataLinesOut))
    else $error("driven byte changed");
  // Register bus answers one cycle after the take and stands until taken
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write answer late");
  wr_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer late");
  rd_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  // Main scenarios
  pin_read_c: cover property (busStrobe && readWriteSelect ##1 dataLinesOe);
  bus_write_c: cover property (s_axi_bvalid && s_axi_bready);
  bus_read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule

/* testbench/lcdp_host_model.sv */
// Host microcontroller model driving the parallel display bus.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/10ps
module lcdp_host_model (
  // Clock
  input wire logic       clk_sys,
  // Host pins
  output logic           registerSelect,
  output logic           readWriteSelect,
  output logic           busStrobe,
  output logic [7:0]     dataLinesIn,
  // Device drive
  input wire logic [7:0] dataLinesOut,
  input wire logic       dataLinesOe
);
  logic [7:0] hostData;
  logic       hostOe;
  logic [7:0] lastLvl;
  // Resolved wire; an undriven bus toggles so stale values never match
  assign dataLinesIn = dataLinesOe ? dataLinesOut : (hostOe ? hostData : ~lastLvl);
  always @(posedge clk_sys) lastLvl <= dataLinesIn;
  initial begin
    registerSelect = 1'b0;
    readWriteSelect = 1'b0;
    busStrobe = 1'b0;
    hostData = 8'h00;
    hostOe = 1'b0;
    lastLvl = 8'h00;
  end
  // One strobed transfer; host drives only when writing
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    registerSelect <= rs;
    readWriteSelect <= rw;
    hostData <= ~d; // Wrong byte while the strobe rises
    hostOe <= !rw;
    busStrobe <= 1'b1;
    @(posedge clk_sys);
    hostData <= d; // only the value at the fall may count
    repeat (2) @(posedge clk_sys);
    q = dataLinesIn;
    busStrobe <= 1'b0;
    repeat (2) @(posedge clk_sys);
    hostOe <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Byte write; four-line width sends high nibble first, low lines junk
  task automatic hostWr(input logic rs, input logic [7:0] b, input logic w8);
    logic [7:0] q;
    if (w8) begin
      xfer(rs, 1'b0, b, q);
    end else begin
      xfer(rs, 1'b0, {b[7:4], 4'h9}, q);
      xfer(rs, 1'b0, {b[3:0], 4'h6}, q);
    end
  endtask
  // Byte read as {first strobe, second strobe or zero}
  task automatic hostRd(input logic rs, input logic w8, output logic [15:0] r);
    logic [7:0] q;
    xfer(rs, 1'b1, 8'h00, q);
    r = {q, 8'h00};
    if (!w8) begin
      xfer(rs, 1'b1, 8'h00, q);
      r[7:0] = q;
    end
  endtask
endmodule

/* testbench/lcdp_host_port_tb_top.sv */
// Self-checking bench for the display port: bus tasks and pin sequences.
// Assumes lcdp_pkg, lcdp_fifo and lcdp_host_port are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nFail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module lcdp_host_port_tb_top;
  import lcdp_pkg::*;
  logic        clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, registerSelect, readWriteSelect, busStrobe, dataLinesOe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dataLinesIn, dataLinesOut;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] hv;
  int          nFail, samplesChecked;
  lcdp_host_port i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .registerSelect, .readWriteSelect, .busStrobe, .dataLinesIn,
    .dataLinesOut, .dataLinesOe);
  lcdp_host_model i_host (.clk_sys, .registerSelect, .readWriteSelect, .busStrobe,
    .dataLinesIn, .dataLinesOut, .dataLinesOe);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic testDone;
    if (nFail == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog; the whole sequence needs well under 3000 cycles
  initial begin
    #100us;
    nFail++;
    testDone;
  end
  // Register write; ready is raised late so the answer must stand
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                       input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
  endtask
  // Register read compared with an expected word and response
  task automatic axiRd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values, unmapped place, disabled byte strobe
    axiRd(LCDP_CTRL_OFS, 32'h00000001, RESP_OKAY);
    axiRd(LCDP_STAT_OFS, 32'h0000000a, RESP_OKAY);
    axiRd(LCDP_RDBYTE_OFS, 32'h00000000, RESP_OKAY);
    axiRd(LCDP_RXDATA_OFS, 32'h00000000, RESP_OKAY);
    axiRd(8'h20, 32'h00000000, RESP_SLVERR);
    axiWr(8'h20, 32'hffffffff, 4'hf, RESP_SLVERR);
    axiWr(LCDP_ADDR_OFS, 32'h0000007f, 4'h0, RESP_OKAY);
    axiRd(LCDP_ADDR_OFS, 32'h00000000, RESP_OKAY);
    // Eight-line data write, then instruction and status reads
    i_host.hostWr(1'b1, 8'ha5, 1'b1);
    axiRd(LCDP_RXDATA_OFS, 32'h800001a5, RESP_OKAY);
    axiRd(LCDP_ADDR_OFS, 32'h00000001, RESP_OKAY);
    i_host.hostWr(1'b0, 8'h85, 1'b1);
    axiRd(LCDP_RXDATA_OFS, 32'h80000085, RESP_OKAY);
    i_host.hostRd(1'b0, 1'b1, hv);
    `CHK("status", 16'h8500, hv)
    axiWr(LCDP_CTRL_OFS, 32'h00000003, 4'h1, RESP_OKAY);
    axiWr(LCDP_RDBYTE_OFS, 32'h0000003c, 4'hf, RESP_OKAY);
    i_host.hostRd(1'b1, 1'b1, hv);
    `CHK("data", 16'h3c00, hv)
    i_host.hostRd(1'b0, 1'b1, hv);
    `CHK("status", 16'h0600, hv)
    // Switch to four-line width and move bytes as nibble pairs
    i_host.hostWr(1'b0, 8'h20, 1'b1);
    axiRd(LCDP_STAT_OFS, 32'h00000001, RESP_OKAY);
    axiRd(LCDP_RXDATA_OFS, 32'h80000020, RESP_OKAY);
    axiWr(LCDP_CTRL_OFS, 32'h00000002, 4'h1, RESP_OKAY);
    i_host.hostWr(1'b1, 8'h5e, 1'b0);
    axiRd(LCDP_RXDATA_OFS, 32'h8000015e, RESP_OKAY);
    axiWr(LCDP_RDBYTE_OFS, 32'h000000c3, 4'hf, RESP_OKAY);
    i_host.hostRd(1'b1, 1'b0, hv);
    `CHK("nibbles", 16'hc030, hv)
    i_host.hostRd(1'b0, 1'b0, hv);
    `CHK("status", 16'h0080, hv)
    i_host.hostWr(1'b0, 8'h30, 1'b0);
    axiRd(LCDP_STAT_OFS, 32'h00000009, RESP_OKAY);
    axiRd(LCDP_RXDATA_OFS, 32'h80000030, RESP_OKAY);
    axiWr(LCDP_CTRL_OFS, 32'h00000003, 4'h1, RESP_OKAY);
    // Fill the buffer past full, drain it, clear the overflow flag
    for (int i = 0; i < 17; i++) begin
      i_host.hostWr(1'b1, 8'(8'h10 + i), 1'b1);
    end
    axiRd(LCDP_STAT_OFS, 32'h0000000d, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      axiRd(LCDP_RXDATA_OFS, 32'h80000110 + 32'(i), RESP_OKAY);
    end
    axiRd(LCDP_STAT_OFS, 32'h0000000e, RESP_OKAY);
    axiWr(LCDP_STAT_OFS, 32'h00000004, 4'h1, RESP_OKAY);
    axiRd(LCDP_STAT_OFS, 32'h0000000a, RESP_OKAY);
    testDone;
  end
endmodule
bind lcdp_host_port lcdp_host_port_chk i_chk (.clk_sys, .rst, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .readWriteSelect, .busStrobe, .dataLinesOut, .dataLinesOe);
